// ===== nrsta_top.sv
// Network reference selection and link timeout reaction for the drive option interface
//
// Behaviour
// RULE_01: Link mode setting holds 0 to 3, resets to 0; 3 means fieldbus control.
// RULE_02: Priority order: per-unit freq, hertz freq, speed, torque, torque current, PID.
// RULE_03: Main reference is the highest-priority non-zero network reference.
// RULE_04: Action 0 or 4 to 9: coast at once and raise network trip on timeout.
// RULE_05: Action 1: wait the delay, then coast and trip; delay 0.0 to 60.0 s.
// RULE_06: Action 2: link restored within delay cancels; else coast and trip.
// RULE_07: Action 3 or 13 to 15: keep running, never raise the network trip.
// RULE_08: Action 10: decelerate at once using decel time, trip only after stopping.
// RULE_09: Action 11: wait the delay, then decelerate, trip once stopped.
// RULE_10: Action 12: restore within delay cancels; else decelerate after delay, then trip.
// RULE_11: Delay kept in tenths of seconds, timer runs from link loss, clears on restore; the timer only clears on restore for actions 2 and 12.
`timescale 1ns/100ps
module nrsta_top #(
	parameter int CYCLES_PER_TENTH = nrsta_pkg::CYCLES_PER_TENTH
) (
	input wire logic clk_in,
	input wire logic nrst_in,
	input wire logic mode_wr_in,
	input wire logic [nrsta_pkg::MODE_W-1:0] bus_link_mode_select_in,
	input wire logic action_wr_in,
	input wire logic [nrsta_pkg::ACTION_W-1:0] timeout_action_select_in,
	input wire logic delay_wr_in,
	input wire logic [nrsta_pkg::DELAY_W-1:0] timeout_delay_time_in,
	input wire logic [nrsta_pkg::DECEL_W-1:0] decel_time_setting_in,
	input wire logic [nrsta_pkg::REF_W-1:0] frequency_ref_per_unit_in,
	input wire logic [nrsta_pkg::REF_W-1:0] frequency_ref_hertz_in,
	input wire logic [nrsta_pkg::REF_W-1:0] speed_command_ref_in,
	input wire logic [nrsta_pkg::REF_W-1:0] torque_command_ref_in,
	input wire logic [nrsta_pkg::REF_W-1:0] torque_current_ref_in,
	input wire logic [nrsta_pkg::REF_W-1:0] pid_command_ref_in,
	input wire logic link_lost_in,
	input wire logic drive_stopped_in,
	input wire logic trip_reset_in,
	output logic [nrsta_pkg::MODE_W-1:0] bus_link_mode_select_out,
	output logic [nrsta_pkg::ACTION_W-1:0] timeout_action_select_out,
	output logic [nrsta_pkg::DELAY_W-1:0] timeout_delay_time_out,
	output logic fieldbus_control_out,
	output logic [nrsta_pkg::REF_W-1:0] main_ref_out,
	output logic [nrsta_pkg::SRC_W-1:0] ref_source_out,
	output logic coast_stop_out,
	output logic decel_stop_out,
	output logic [nrsta_pkg::DECEL_W-1:0] decel_time_out,
	output logic network_error_trip_out,
	output logic timeout_pending_out
);
	// ==========================================================
	// Helper functions
	// ==========================================================
	// Map the action code to its reaction class
	function automatic nrsta_pkg::nrsta_class_t nrsta_classify(
		input logic [nrsta_pkg::ACTION_W-1:0] code
	);
		nrsta_pkg::nrsta_class_t cl;
		cl = nrsta_pkg::NRSTA_CL_IGNORE; // RULE_07
		if (code == nrsta_pkg::ACT_COAST_NOW)
			cl = nrsta_pkg::NRSTA_CL_COAST_NOW; // RULE_04
		else if (code >= nrsta_pkg::ACT_COAST_LO && code <= nrsta_pkg::ACT_COAST_HI)
			cl = nrsta_pkg::NRSTA_CL_COAST_NOW; // RULE_04
		else if (code == nrsta_pkg::ACT_COAST_DELAY)
			cl = nrsta_pkg::NRSTA_CL_COAST_DELAY; // RULE_05
		else if (code == nrsta_pkg::ACT_COAST_RETRY)
			cl = nrsta_pkg::NRSTA_CL_COAST_RETRY; // RULE_06
		else if (code == nrsta_pkg::ACT_DECEL_NOW)
			cl = nrsta_pkg::NRSTA_CL_DECEL_NOW; // RULE_08
		else if (code == nrsta_pkg::ACT_DECEL_DELAY)
			cl = nrsta_pkg::NRSTA_CL_DECEL_DELAY; // RULE_09
		else if (code == nrsta_pkg::ACT_DECEL_RETRY)
			cl = nrsta_pkg::NRSTA_CL_DECEL_RETRY; // RULE_10
		return cl;
	endfunction

	// True for classes where a restored link cancels the pending reaction
	function automatic logic nrsta_is_retry(input nrsta_pkg::nrsta_class_t cl);
		return (cl == nrsta_pkg::NRSTA_CL_COAST_RETRY) || (cl == nrsta_pkg::NRSTA_CL_DECEL_RETRY);
	endfunction

	// True for classes that end in a controlled deceleration
	function automatic logic nrsta_is_decel(input nrsta_pkg::nrsta_class_t cl);
		return (cl == nrsta_pkg::NRSTA_CL_DECEL_NOW) || (cl == nrsta_pkg::NRSTA_CL_DECEL_DELAY)
			|| (cl == nrsta_pkg::NRSTA_CL_DECEL_RETRY);
	endfunction

	// ==========================================================
	// Settings
	// ==========================================================
	logic [nrsta_pkg::MODE_W-1:0] link_mode;
	logic [nrsta_pkg::ACTION_W-1:0] action_sel;
	logic [nrsta_pkg::DELAY_W-1:0] delay_tenths;
	nrsta_pkg::nrsta_class_t action_class;

	// Link mode; the 2-bit field cannot hold anything outside 0 to 3
	always_ff @(posedge clk_in)
	begin
		if (!nrst_in)
			link_mode <= nrsta_pkg::MODE_RESET; // RULE_01
		else if (mode_wr_in)
			link_mode <= bus_link_mode_select_in; // RULE_01
	end

	// Timeout action code; all sixteen codes are legal
	always_ff @(posedge clk_in)
	begin
		if (!nrst_in)
			action_sel <= nrsta_pkg::ACTION_RESET;
		else if (action_wr_in)
			action_sel <= timeout_action_select_in;
	end

	// Delay in tenths; writes above 60.0 s are dropped, old value kept
	always_ff @(posedge clk_in)
	begin
		if (!nrst_in)
			delay_tenths <= nrsta_pkg::DELAY_RESET;
		else if (delay_wr_in && timeout_delay_time_in <= nrsta_pkg::DELAY_MAX_TENTHS)
			delay_tenths <= timeout_delay_time_in; // RULE_05 RULE_11
	end

	assign action_class = nrsta_classify(action_sel);

	// Settings read back
	always_ff @(posedge clk_in)
	begin
		if (!nrst_in)
		begin
			bus_link_mode_select_out <= nrsta_pkg::MODE_RESET;
			timeout_action_select_out <= nrsta_pkg::ACTION_RESET;
			timeout_delay_time_out <= nrsta_pkg::DELAY_RESET;
			fieldbus_control_out <= 1'b0;
		end
		else
		begin
			bus_link_mode_select_out <= link_mode;
			timeout_action_select_out <= action_sel;
			timeout_delay_time_out <= delay_tenths;
			fieldbus_control_out <= (link_mode == nrsta_pkg::MODE_FIELDBUS); // RULE_01
		end
	end

	// ==========================================================
	// Reference selection
	// ==========================================================
	nrsta_ref_if #(.W(nrsta_pkg::REF_W), .N(nrsta_pkg::NUM_REFS)) ref_bus ();

	// Slot order sets the priority, slot 0 highest
	assign ref_bus.ref_val[nrsta_pkg::SRC_FREQ_PU] = frequency_ref_per_unit_in; // RULE_02
	assign ref_bus.ref_val[nrsta_pkg::SRC_FREQ_HZ] = frequency_ref_hertz_in;
	assign ref_bus.ref_val[nrsta_pkg::SRC_SPEED] = speed_command_ref_in;
	assign ref_bus.ref_val[nrsta_pkg::SRC_TORQUE] = torque_command_ref_in;
	assign ref_bus.ref_val[nrsta_pkg::SRC_TORQUE_CUR] = torque_current_ref_in;
	assign ref_bus.ref_val[nrsta_pkg::SRC_PID] = pid_command_ref_in;

	nrsta_ref_select #(.N(nrsta_pkg::NUM_REFS), .W(nrsta_pkg::REF_W)) i_nrsta_ref_select (
		.refs(ref_bus)
	);

	// Network reference only drives the motor under fieldbus control
	always_ff @(posedge clk_in)
	begin
		if (!nrst_in)
		begin
			main_ref_out <= '0;
			ref_source_out <= nrsta_pkg::SRC_NONE;
		end
		else if (link_mode == nrsta_pkg::MODE_FIELDBUS && ref_bus.any_nonzero)
		begin
			main_ref_out <= ref_bus.main_ref; // RULE_03
			ref_source_out <= ref_bus.src_idx;
		end
		else
		begin
			main_ref_out <= '0;
			ref_source_out <= nrsta_pkg::SRC_NONE;
		end
	end

	// ==========================================================
	// Link loss input
	// ==========================================================
	// The link status comes from the network side, so two flops first
	logic link_lost_meta;
	logic link_lost_sync;
	logic link_lost_prev;
	logic timeout_event;

	always_ff @(posedge clk_in)
	begin
		if (!nrst_in)
		begin
			link_lost_meta <= 1'b0;
			link_lost_sync <= 1'b0;
			link_lost_prev <= 1'b0;
		end
		else
		begin
			link_lost_meta <= link_lost_in;
			link_lost_sync <= link_lost_meta;
			link_lost_prev <= link_lost_sync;
		end
	end

	assign timeout_event = link_lost_sync & ~link_lost_prev;

	// ==========================================================
	// Reaction state machine
	// ==========================================================
	typedef enum {
		NRSTA_ST_IDLE,
		NRSTA_ST_WAIT,
		NRSTA_ST_COAST,
		NRSTA_ST_DECEL,
		NRSTA_ST_TRIPPED
	} nrsta_state_t;

	localparam int PRESCALE_BITS = nrsta_pkg::PRESCALE_W;
	localparam logic [PRESCALE_BITS-1:0] PRESCALE_LAST = PRESCALE_BITS'(CYCLES_PER_TENTH - 1);

	nrsta_state_t state;
	nrsta_state_t next_state;
	logic [PRESCALE_BITS-1:0] prescale;
	logic [nrsta_pkg::DELAY_W-1:0] tenths;
	logic delay_done;
	logic reaction_decel;

	// Delay is over once the tenths count reaches the setting; 0.0 s expires at once
	assign delay_done = (tenths >= delay_tenths); // RULE_05 RULE_11

	// Delay timer: runs only while waiting, cleared on every other state
	always_ff @(posedge clk_in)
	begin
		if (!nrst_in || state != NRSTA_ST_WAIT)
		begin
			prescale <= '0; // RULE_11
			tenths <= '0;
		end
		else if (prescale == PRESCALE_LAST)
		begin
			prescale <= '0;
			tenths <= tenths + 1'b1; // RULE_11
		end
		else
			prescale <= prescale + 1'b1;
	end

	// Next-state decode
	always_comb
	begin
		next_state = state;
		case (state)
			NRSTA_ST_IDLE:
			begin
				if (timeout_event)
				begin
					case (action_class)
						nrsta_pkg::NRSTA_CL_COAST_NOW: next_state = NRSTA_ST_COAST; // RULE_04
						nrsta_pkg::NRSTA_CL_DECEL_NOW: next_state = NRSTA_ST_DECEL; // RULE_08
						nrsta_pkg::NRSTA_CL_IGNORE: next_state = NRSTA_ST_IDLE; // RULE_07
						default: next_state = NRSTA_ST_WAIT; // RULE_05 RULE_06 RULE_09 RULE_10
					endcase
				end
			end
			NRSTA_ST_WAIT:
			begin
				// Restore check comes first: for retry actions a link back in time always cancels
				if (nrsta_is_retry(action_class) && !link_lost_sync)
					next_state = NRSTA_ST_IDLE; // RULE_06 RULE_10
				else if (delay_done)
					next_state = reaction_decel ? NRSTA_ST_DECEL : NRSTA_ST_COAST; // RULE_05 RULE_09
			end
			NRSTA_ST_COAST:
				next_state = NRSTA_ST_TRIPPED;
			NRSTA_ST_DECEL:
			begin
				if (drive_stopped_in)
					next_state = NRSTA_ST_TRIPPED; // RULE_08 RULE_09 RULE_10
			end
			NRSTA_ST_TRIPPED:
			begin
				// Trip stays while the link is still down, so a reset cannot hide it
				if (trip_reset_in && !link_lost_sync)
					next_state = NRSTA_ST_IDLE;
			end
			default:
				next_state = NRSTA_ST_IDLE;
		endcase
	end

	// Coast or decel choice is frozen when the wait starts; the retry cancel in the wait still reads the live action
	always_ff @(posedge clk_in)
	begin
		if (!nrst_in)
			reaction_decel <= 1'b0;
		else if (state == NRSTA_ST_IDLE)
			reaction_decel <= nrsta_is_decel(action_class);
	end

	// State register
	always_ff @(posedge clk_in)
	begin
		if (!nrst_in)
			state <= NRSTA_ST_IDLE;
		else
			state <= next_state;
	end

	// ==========================================================
	// Reaction outputs
	// ==========================================================
	// Decoded from next_state so each output is a flop that tracks the state
	always_ff @(posedge clk_in)
	begin
		if (!nrst_in)
		begin
			coast_stop_out <= 1'b0;
			decel_stop_out <= 1'b0;
			network_error_trip_out <= 1'b0;
			timeout_pending_out <= 1'b0;
		end
		else
		begin
			// Coasting trips together with the stop; decel trips only when halted
			coast_stop_out <= (next_state == NRSTA_ST_COAST)
				|| (next_state == NRSTA_ST_TRIPPED && !reaction_decel); // RULE_04 RULE_05 RULE_06
			decel_stop_out <= (next_state == NRSTA_ST_DECEL)
				|| (next_state == NRSTA_ST_TRIPPED && reaction_decel); // RULE_08 RULE_09 RULE_10
			network_error_trip_out <= (next_state == NRSTA_ST_COAST)
				|| (next_state == NRSTA_ST_TRIPPED); // RULE_04 RULE_08
			timeout_pending_out <= (next_state == NRSTA_ST_WAIT);
		end
	end

	// Decel time handed to the ramp every cycle, in every state
	always_ff @(posedge clk_in)
	begin
		if (!nrst_in)
			decel_time_out <= '0;
		else
			decel_time_out <= decel_time_setting_in; // RULE_08
	end
endmodule // nrsta_top

// ===== nrsta_pkg.sv
// Package with constants shared by the network reference select and timeout action block
package nrsta_pkg;
	// ==========================================================
	// Widths
	// ==========================================================
	localparam int REF_W = 16;
	localparam int NUM_REFS = 6;
	localparam int SRC_W = 3;
	localparam int MODE_W = 2;
	localparam int ACTION_W = 4;
	localparam int DELAY_W = 10;
	localparam int PRESCALE_W = 24;
	localparam int DECEL_W = 16;

	// ==========================================================
	// Reset values and setting limits
	// ==========================================================
	localparam logic [MODE_W-1:0] MODE_RESET = 2'h0;
	localparam logic [MODE_W-1:0] MODE_FIELDBUS = 2'h3;
	localparam logic [ACTION_W-1:0] ACTION_RESET = 4'h0;
	localparam logic [DELAY_W-1:0] DELAY_RESET = 10'h000;
	localparam logic [DELAY_W-1:0] DELAY_MAX_TENTHS = 10'h258;

	// ==========================================================
	// Reference slots, highest priority first
	// ==========================================================
	localparam logic [SRC_W-1:0] SRC_FREQ_PU = 3'h0;
	localparam logic [SRC_W-1:0] SRC_FREQ_HZ = 3'h1;
	localparam logic [SRC_W-1:0] SRC_SPEED = 3'h2;
	localparam logic [SRC_W-1:0] SRC_TORQUE = 3'h3;
	localparam logic [SRC_W-1:0] SRC_TORQUE_CUR = 3'h4;
	localparam logic [SRC_W-1:0] SRC_PID = 3'h5;
	localparam logic [SRC_W-1:0] SRC_NONE = 3'h7;

	// ==========================================================
	// Timeout action codes
	// ==========================================================
	localparam logic [ACTION_W-1:0] ACT_COAST_NOW = 4'h0;
	localparam logic [ACTION_W-1:0] ACT_COAST_DELAY = 4'h1;
	localparam logic [ACTION_W-1:0] ACT_COAST_RETRY = 4'h2;
	localparam logic [ACTION_W-1:0] ACT_IGNORE = 4'h3;
	localparam logic [ACTION_W-1:0] ACT_COAST_LO = 4'h4;
	localparam logic [ACTION_W-1:0] ACT_COAST_HI = 4'h9;
	localparam logic [ACTION_W-1:0] ACT_DECEL_NOW = 4'hA;
	localparam logic [ACTION_W-1:0] ACT_DECEL_DELAY = 4'hB;
	localparam logic [ACTION_W-1:0] ACT_DECEL_RETRY = 4'hC;

	// Decoded reaction classes
	typedef enum {
		NRSTA_CL_COAST_NOW,
		NRSTA_CL_COAST_DELAY,
		NRSTA_CL_COAST_RETRY,
		NRSTA_CL_DECEL_NOW,
		NRSTA_CL_DECEL_DELAY,
		NRSTA_CL_DECEL_RETRY,
		NRSTA_CL_IGNORE
	} nrsta_class_t;

	// ==========================================================
	// Timing: delay unit is one tenth of a second
	// ==========================================================
	localparam longint CLK_PERIOD_NS = 8;
	localparam longint DELAY_UNIT_MS = 100;
	localparam longint NS_PER_MS = 1000000;
	localparam int CYCLES_PER_TENTH = int'((DELAY_UNIT_MS * NS_PER_MS) / CLK_PERIOD_NS);
endpackage

// ===== nrsta_ref_if.sv
// Interface carrying the network references to the selector and its choice back
`timescale 1ns/100ps
interface nrsta_ref_if #(
	parameter int W = nrsta_pkg::REF_W,
	parameter int N = nrsta_pkg::NUM_REFS
);
	logic [W-1:0] ref_val [N];
	logic [W-1:0] main_ref;
	logic [nrsta_pkg::SRC_W-1:0] src_idx;
	logic any_nonzero;

	modport sel (input ref_val, output main_ref, output src_idx, output any_nonzero);
	modport top (output ref_val, input main_ref, input src_idx, input any_nonzero);
endinterface // nrsta_ref_if

// ===== nrsta_ref_select.sv
// Fixed-priority selector picking the main reference among network references
`timescale 1ns/100ps
module nrsta_ref_select #(
	parameter int N = nrsta_pkg::NUM_REFS,
	parameter int W = nrsta_pkg::REF_W
) (
	nrsta_ref_if.sel refs
);
	// ==========================================================
	// Priority chain
	// ==========================================================
	// Chain runs from the lowest slot up so slot 0 overrides everything
	logic [W-1:0] chain_ref [N+1];
	logic [nrsta_pkg::SRC_W-1:0] chain_idx [N+1];
	logic chain_hit [N+1];

	// Tail of the chain: nothing found
	assign chain_ref[N] = '0;
	assign chain_idx[N] = nrsta_pkg::SRC_NONE;
	assign chain_hit[N] = 1'b0;

	// Each stage takes its own slot when non-zero, else passes the lower result
	genvar g;
	generate
		for (g = 0; g < N; g++)
		begin : g_stage
			assign chain_ref[g] = (refs.ref_val[g] != '0) ? refs.ref_val[g] : chain_ref[g+1]; // RULE_03
			assign chain_idx[g] = (refs.ref_val[g] != '0) ? nrsta_pkg::SRC_W'(g) : chain_idx[g+1]; // RULE_02
			assign chain_hit[g] = (refs.ref_val[g] != '0) | chain_hit[g+1];
		end
	endgenerate

	// Head of the chain is the winner
	assign refs.main_ref = chain_ref[0];
	assign refs.src_idx = chain_idx[0];
	assign refs.any_nonzero = chain_hit[0];
endmodule // nrsta_ref_select

// ===== nrsta_partner.sv
// Network controller model that writes the drive references and holds the link state
`timescale 1ns/100ps
module nrsta_partner (
	input wire logic clk_in,
	input wire logic nrst_in,
	input wire logic wr_in,
	input wire logic [2:0] slot_in,
	input wire logic [15:0] val_in,
	input wire logic drop_in,
	output logic [5:0][15:0] refs_out,
	output logic link_lost_out
);
	// ==========================================================
	// Reference words and link state
	// ==========================================================
	// One slot per cycle, as a controller writes one word per message
	always_ff @(posedge clk_in)
	begin
		if (!nrst_in)
		begin
			refs_out <= '0;
			link_lost_out <= 1'h0;
		end
		else
		begin
			if (wr_in)
				refs_out[slot_in] <= val_in;
			link_lost_out <= drop_in;
		end
	end
endmodule // nrsta_partner

// ===== nrsta_top_asserts.sv
// Checker for settings, reference choice and timeout reaction at the top ports
`timescale 1ns/100ps
module nrsta_top_asserts #(
	parameter int CYCLES_PER_TENTH = 10
) (
	input wire logic clk_in,
	input wire logic nrst_in,
	input wire logic mode_wr_in,
	input wire logic [1:0] bus_link_mode_select_in,
	input wire logic delay_wr_in,
	input wire logic [9:0] timeout_delay_time_in,
	input wire logic [15:0] decel_time_setting_in,
	input wire logic [15:0] frequency_ref_per_unit_in,
	input wire logic [15:0] frequency_ref_hertz_in,
	input wire logic link_lost_in,
	input wire logic drive_stopped_in,
	input wire logic [1:0] bus_link_mode_select_out,
	input wire logic [3:0] timeout_action_select_out,
	input wire logic [9:0] timeout_delay_time_out,
	input wire logic fieldbus_control_out,
	input wire logic [15:0] main_ref_out,
	input wire logic [2:0] ref_source_out,
	input wire logic coast_stop_out,
	input wire logic decel_stop_out,
	input wire logic [15:0] decel_time_out,
	input wire logic network_error_trip_out,
	input wire logic timeout_pending_out
);
	// ==========================================================
	// Helper logic
	// ==========================================================
	int pend_cnt;
	logic idle;
	logic [3:0] act;
	assign act = timeout_action_select_out;
	assign idle = !(coast_stop_out || decel_stop_out || network_error_trip_out || timeout_pending_out);
	// Wait length so far; cleared whenever the timer is not running
	always_ff @(posedge clk_in)
	begin
		if (!nrst_in || !timeout_pending_out)
			pend_cnt <= 0;
		else
			pend_cnt <= pend_cnt + 1;
	end
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!nrst_in);
	// ==========================================================
	// Assertions
	// ==========================================================
	a_mode_readback: assert property (
		mode_wr_in |-> ##2 bus_link_mode_select_out == $past(bus_link_mode_select_in, 2))
		else $error("mode readback wrong");
	a_fieldbus_flag: assert property (
		fieldbus_control_out == (bus_link_mode_select_out == 2'h3))
		else $error("fieldbus flag wrong");
	a_delay_refused: assert property (
		delay_wr_in && timeout_delay_time_in > 10'h258 |-> ##2 $stable(timeout_delay_time_out))
		else $error("long delay taken");
	a_ref_zero: assert property (
		!fieldbus_control_out |-> main_ref_out == 16'h0000 && ref_source_out == 3'h7)
		else $error("ref passed outside fieldbus");
	a_ref_top: assert property (
		fieldbus_control_out && $past(frequency_ref_per_unit_in) != 16'h0000
		|-> main_ref_out == $past(frequency_ref_per_unit_in) && ref_source_out == 3'h0)
		else $error("top ref not chosen");
	a_ref_second: assert property (
		fieldbus_control_out && $past(frequency_ref_per_unit_in) == 16'h0000
		&& $past(frequency_ref_hertz_in) != 16'h0000 |-> ref_source_out == 3'h1)
		else $error("second ref not chosen");
	a_coast_now: assert property (
		$rose(link_lost_in) && idle && (act == 4'h0 || (act >= 4'h4 && act <= 4'h9))
		|-> ##3 coast_stop_out && network_error_trip_out)
		else $error("no coast trip");
	a_decel_now: assert property (
		$rose(link_lost_in) && idle && act == 4'hA
		|-> ##3 decel_stop_out && !network_error_trip_out)
		else $error("no decel stop");
	a_trip_stop: assert property (
		$rose(network_error_trip_out) && decel_stop_out |-> $past(drive_stopped_in))
		else $error("trip before stop");
	a_ignore_quiet: assert property (
		(act == 4'h3 || act >= 4'hD) && !network_error_trip_out
		|=> !network_error_trip_out && !coast_stop_out)
		else $error("ignored timeout acted");
	a_pending_bound: assert property (
		timeout_pending_out |-> pend_cnt <= timeout_delay_time_out * CYCLES_PER_TENTH + 3)
		else $error("wait too long");
	a_decel_pass: assert property (
		$past(nrst_in) |-> decel_time_out == $past(decel_time_setting_in))
		else $error("decel time wrong");
	c_coast: cover property ($rose(coast_stop_out));
	c_decel_trip: cover property ($rose(network_error_trip_out) && decel_stop_out);
	c_cancel: cover property ($fell(timeout_pending_out) && !coast_stop_out && !decel_stop_out);
endmodule // nrsta_top_asserts

bind nrsta_top nrsta_top_asserts #(.CYCLES_PER_TENTH(CYCLES_PER_TENTH)) i_nrsta_top_asserts (
	.clk_in, .nrst_in, .mode_wr_in, .bus_link_mode_select_in, .delay_wr_in,
	.timeout_delay_time_in, .decel_time_setting_in, .frequency_ref_per_unit_in,
	.frequency_ref_hertz_in, .link_lost_in, .drive_stopped_in, .bus_link_mode_select_out,
	.timeout_action_select_out, .timeout_delay_time_out, .fieldbus_control_out,
	.main_ref_out, .ref_source_out, .coast_stop_out, .decel_stop_out, .decel_time_out,
	.network_error_trip_out, .timeout_pending_out);

// ===== nrsta_top_bench.sv
// Self-checking bench for reference selection and network timeout reaction
`timescale 1ns/100ps
module nrsta_top_bench;
	logic clk_in = 1'h0;
	logic nrst_in = 1'h0;
	logic mode_wr = 1'h0, action_wr = 1'h0, delay_wr = 1'h0, p_wr = 1'h0, p_drop = 1'h0;
	logic stopped = 1'h0, trip_rst = 1'h0;
	logic [1:0] mode_v = 2'h0;
	logic [3:0] act_v = 4'h0;
	logic [9:0] dly_v = 10'h000;
	logic [15:0] decel_v = 16'h0000, p_val = 16'h0000;
	logic [2:0] p_slot = 3'h0;
	logic [5:0][15:0] refs;
	logic link_lost, fb_o, co_o, de_o, tr_o, pend_o;
	logic [1:0] mode_o;
	logic [3:0] act_o;
	logic [9:0] dly_o;
	logic [15:0] ref_o;
	logic [2:0] src_o;
	logic [38:0] obs, last, cur, q[$];
	logic [1:0] e_mode = 2'h0;
	logic [3:0] e_act = 4'h0;
	logic [9:0] e_dly = 10'h000;
	logic [5:0][15:0] e_ref = '0;
	logic e_co = 1'h0, e_de = 1'h0, e_tr = 1'h0;
	int err_count = 0, n_tests = 0, seed = 89;
	assign obs = {mode_o, act_o, dly_o, fb_o, ref_o, src_o, co_o, de_o, tr_o};
	// ==========================================================
	// Clock, far side and design
	// ==========================================================
	always #4 clk_in = ~clk_in;
	always @(posedge clk_in) decel_v <= 16'($random(seed));
	nrsta_partner i_nrsta_partner (.clk_in(clk_in), .nrst_in(nrst_in), .wr_in(p_wr),
		.slot_in(p_slot), .val_in(p_val), .drop_in(p_drop), .refs_out(refs),
		.link_lost_out(link_lost));
	nrsta_top #(.CYCLES_PER_TENTH(10)) i_nrsta_top (.clk_in(clk_in), .nrst_in(nrst_in),
		.mode_wr_in(mode_wr), .bus_link_mode_select_in(mode_v), .action_wr_in(action_wr),
		.timeout_action_select_in(act_v), .delay_wr_in(delay_wr),
		.timeout_delay_time_in(dly_v), .decel_time_setting_in(decel_v),
		.frequency_ref_per_unit_in(refs[0]), .frequency_ref_hertz_in(refs[1]),
		.speed_command_ref_in(refs[2]), .torque_command_ref_in(refs[3]),
		.torque_current_ref_in(refs[4]), .pid_command_ref_in(refs[5]),
		.link_lost_in(link_lost), .drive_stopped_in(stopped), .trip_reset_in(trip_rst),
		.bus_link_mode_select_out(mode_o), .timeout_action_select_out(act_o),
		.timeout_delay_time_out(dly_o), .fieldbus_control_out(fb_o), .main_ref_out(ref_o),
		.ref_source_out(src_o), .coast_stop_out(co_o), .decel_stop_out(de_o),
		.decel_time_out(), .network_error_trip_out(tr_o), .timeout_pending_out(pend_o));
	// ==========================================================
	// Expectation model and comparison
	// ==========================================================
	// Scan from lowest priority up so the highest non-zero slot wins last
	function automatic logic [38:0] exp_obs();
		logic [15:0] r;
		logic [2:0] s;
		r = 16'h0000;
		s = 3'h7;
		for (int i = 5; i >= 0; i--)
			if (e_mode == 2'h3 && e_ref[i] != 16'h0000)
			begin
				r = e_ref[i];
				s = 3'(i);
			end
		return {e_mode, e_act, e_dly, e_mode == 2'h3, r, s, e_co, e_de, e_tr};
	endfunction
	task automatic check(input logic [38:0] seen, input logic [38:0] want);
		n_tests++;
		if (seen !== want)
		begin
			err_count++;
			$display("Error at %0t: saw %h, expected %h", $time, seen, want);
		end
	endtask
	// Queue only real changes, since the monitor fires on changes alone
	task automatic note();
		logic [38:0] o;
		o = exp_obs();
		if (o !== cur)
			q.push_back(o);
		cur = o;
	endtask
	// An output change with nothing queued compares against the old state and fails
	always @(negedge clk_in)
	begin
		if (nrst_in && obs !== last)
			check(obs, q.size() == 0 ? last : q.pop_front());
		last = obs;
	end
	// k: 0 mode, 1 action, 2 delay, 3 and up reference slot
	task automatic put(input int k, input logic [15:0] v);
		@(posedge clk_in);
		{mode_v, act_v, dly_v, p_val, p_slot} <= {v[1:0], v[3:0], v[9:0], v, 3'(k - 3)};
		{mode_wr, action_wr, delay_wr, p_wr} <= {k == 0, k == 1, k == 2, k >= 3};
		@(posedge clk_in);
		{mode_wr, action_wr, delay_wr, p_wr} <= 4'h0;
		if (k == 0)
			e_mode = v[1:0];
		else if (k == 1)
			e_act = v[3:0];
		else if (k == 2 && v <= 16'h0258)
			e_dly = v[9:0];
		else if (k >= 3)
			e_ref[k - 3] = v;
		note();
	endtask
	task automatic pulse_reset();
		@(posedge clk_in);
		trip_rst <= 1'h1;
		@(posedge clk_in);
		trip_rst <= 1'h0;
		repeat (3) @(posedge clk_in);
	endtask
	// Drop the link under one action code and time the reaction
	task automatic run_to(input logic [3:0] code, input bit early);
		int n, d;
		bit slow, none, dec;
		put(1, 16'(code));
		d = 10 * e_dly;
		dec = code >= 4'hA && code <= 4'hC;
		slow = code inside {4'h1, 4'h2, 4'hB, 4'hC};
		none = code == 4'h3 || code >= 4'hD || early;
		{e_co, e_de, e_tr} = none ? 3'h0 : dec ? 3'h2 : 3'h5;
		note();
		repeat (4) @(posedge clk_in);
		p_drop <= 1'h1;
		@(posedge clk_in);
		n = 0;
		while (n < 40 && co_o !== 1'h1 && de_o !== 1'h1)
		begin
			@(negedge clk_in);
			n++;
			if (n == 5)
				check(39'(pend_o), 39'(slow));
			if (early && n == 6)
				@(posedge clk_in) p_drop <= 1'h0;
		end
		if (slow && !none)
			check(39'(n >= d + 3 && n <= d + 8), 39'h1);
		else
			check(39'(n), 39'(none ? 40 : 4));
		check(39'(pend_o), 39'h0);
		if (dec && !none)
		begin
			repeat (3) @(posedge clk_in);
			stopped <= 1'h1;
			e_tr = 1'h1;
			note();
		end
		pulse_reset();
		p_drop <= 1'h0;
		repeat (4) @(posedge clk_in);
		{e_co, e_de, e_tr} = 3'h0;
		note();
		pulse_reset();
		stopped <= 1'h0;
	endtask
	task automatic summarize();
		$display("Counts: %0d compares, %0d mismatches", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// ==========================================================
	// Tests
	// ==========================================================
	initial
	begin
		cur = exp_obs();
		repeat (5) @(posedge clk_in);
		nrst_in <= 1'h1;
		repeat (2) @(negedge clk_in);
		check(obs, cur);
		$display("test reset done");
		put(0, 16'h0002);
		put(2, 16'h0259);
		put(2, 16'h0258);
		put(2, 16'h0002);
		$display("test settings done");
		put(0, 16'h0003);
		for (int i = 0; i < 40; i++)
			put(3 + {$random(seed)} % 6, {$random(seed)} % 3 == 0 ? 16'($random(seed)) : 16'h0000);
		put(3, 16'h00A5);
		put(0, 16'h0001);
		put(0, 16'h0003);
		$display("test priority done");
		for (int i = 0; i < 18; i++)
			run_to(4'(i < 16 ? i : (i == 16 ? 2 : 12)), i >= 16);
		$display("test timeout done");
		repeat (5) @(posedge clk_in);
		check(39'(q.size()), 39'h0);
		summarize();
	end
	// Watchdog: the whole run needs about 870 cycles
	initial
	begin
		repeat (20000) @(posedge clk_in);
		err_count++;
		summarize();
	end
endmodule // nrsta_top_bench
